// file: include/rish_pkg.sv
// constants and types for the reference-input select and holdover controller
// assumes a single 50 MHz clock and an AHB-Lite register port
package rish_pkg;
   // ************************************************************
   // register word indices (each one aligned word, byte address = 4*index)
   // ************************************************************
   // printed offsets are not all multiples of four: each is an index, byte address = 4*index
   localparam logic [11:0] IDX_INPUT_SELECT = 12'h42A;
   localparam logic [11:0] IDX_FAST_ACQ = 12'h42B;
   localparam logic [11:0] IDX_HIST_LEN = 12'h42E;
   localparam logic [11:0] IDX_HIST_DELAY = 12'h42F;
   localparam logic [11:0] IDX_REF_COUNT_FRC = 12'h431;
   localparam logic [11:0] IDX_CYC_COUNT = 12'h432;
   localparam logic [11:0] IDX_FORCE_HOLD = 12'h435;
   localparam logic [11:0] IDX_SWITCH_CTRL = 12'h436;
   localparam logic [11:0] IDX_ALARM_MASKS = 12'h437;
   localparam logic [11:0] IDX_PRIO_01 = 12'h438;
   localparam logic [11:0] IDX_PRIO_23 = 12'h439;
   localparam logic [11:0] IDX_SEAMLESS_MODE = 12'h43A;
   localparam logic [11:0] IDX_PHASE_THR = 12'h43B;
   localparam logic [11:0] IDX_COARSE_LEN = 12'h43D;
   localparam logic [11:0] IDX_COARSE_DLY = 12'h43E;
   localparam logic [11:0] IDX_STATUS = 12'h43F;
   localparam logic [11:0] IDX_FINE_ADJ = 12'h442;
   localparam logic [11:0] IDX_FORCE_FINE = 12'h445;
   // own registers
   localparam logic [11:0] IDX_STEP_WORD_LO = 12'h450;
   localparam logic [11:0] IDX_STEP_WORD_HI = 12'h451;
   localparam logic [11:0] IDX_STEP_CMD = 12'h452;
   localparam logic [11:0] IDX_ACTIVE = 12'h453;
   localparam logic [11:0] IDX_NUMER_LO = 12'h454;
   localparam logic [11:0] IDX_NUMER_HI = 12'h455;
   localparam logic [11:0] IDX_HOLD_FREQ = 12'h456;

   // ************************************************************
   // field positions and widths
   // ************************************************************
   localparam int SEL_W = 3;
   localparam int PRIO_W = 3;
   localparam int NUM_IN = 4;
   localparam int LEN_W = 5;
   localparam int HF_W = 32;
   localparam int STEP_W = 56;
   localparam int FA_AUTO_BIT = 0;
   localparam int FA_FORCE_BIT = 1;
   localparam int FH_BIT = 0;
   localparam int SC_STYLE_BIT = 2;
   localparam int ST_VALID_BIT = 1;
   localparam int ST_FAST_BIT = 2;
   localparam int ST_HOLD_BIT = 3;
   localparam int ST_FREERUN_BIT = 4;
   localparam int CMD_INC_BIT = 0;
   localparam int CMD_DEC_BIT = 1;
   localparam int LOS_LSB = 0;
   localparam int OOF_LSB = 4;
   localparam int PRIO_HI_LSB = 4;
   localparam logic [1:0] MODE_MANUAL = 2'h0;
   localparam logic [1:0] MODE_NONREV = 2'h1;
   localparam logic [1:0] MODE_REV = 2'h2;
   localparam logic [2:0] PRIO_NONE = 3'h0;
   localparam logic [2:0] PRIO_MAX = 3'h4;
   localparam logic [7:0] SEAMLESS_RST = 8'h02;

   // ************************************************************
   // timing: history tick is 268 ns rounded up to 14 clocks (280 ns)
   // ************************************************************
   localparam int CLK_NS = 20;
   localparam int TICK_NS = 268;
   localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;

   typedef enum logic [2:0] {
      RISH_ACQ = 3'b001,
      RISH_TRACK = 3'b010,
      RISH_HOLD = 3'b100
   } rish_state_e;
endpackage

// file: verilog/rish_ctrl.sv
// reference-input selection, fast acquire and holdover history controller
// assumes AHB-Lite single word transfers, one clock, alarms from asynchronous detectors
//
// Functional notes
// R1: step word unsigned; increment adds, decrement subtracts
// R2: manual input choice codes 0-3, 4-7 reserved
// R3: auto fast acquire while unlocked unless forced
// R4: forced fast acquire overrides lock state
// R5: averaging window (2^len - 1) ticks of 268 ns; the code ticks every 14 clocks (280 ns)
// R6: window delayed 2^delay ticks before holdover
// R7: held frequency equals averaged history
// R8: force holdover bit forces holdover
// R9: switch policy manual, nonrevertive, revertive
// R10: switch style glitchless or hitless
// R11: loss masks exclude loss alarms
// R12: deviation masks exclude frequency alarms
// R13: input n uses mask bits n and n+4
// R14: no usable input causes holdover entry
// R15: three-bit ranks, 0 none, 1-4 levels
// R16: software keeps seamless mode field at default
// R17: ten-bit phase threshold over two bytes
// R18: history valid flag read-only status
// R19: fast acquire active flag read-only status
// R20: history accumulation stops in holdover
// R21: valid input clears and restarts history
// R22: automatic picks best-ranked clean input
// R23: revertive returns to better input
//
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/1ps
module rish_ctrl
(
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   input wire logic [rish_pkg::NUM_IN-1:0] signal_loss_alarm_i,
   input wire logic [rish_pkg::NUM_IN-1:0] freq_deviation_alarm_i,
   input wire logic loop_locked_i,
   input wire logic [rish_pkg::HF_W-1:0] input_freq_i,
   output logic [1:0] active_input_o,
   output logic holdover_o,
   output logic freerun_o,
   output logic fast_acquire_o,
   output logic seamless_switch_enable_o,
   output logic [rish_pkg::HF_W-1:0] holdover_freq_o,
   output logic [rish_pkg::STEP_W-1:0] divider_numerator_o
);
   import rish_pkg::*;

   // ************************************************************
   // bus address phase capture
   // ************************************************************
   logic wr_pend_q;
   logic [11:0] wr_idx_q;
   logic [11:0] rd_idx;
   logic rd_phase;
   assign rd_phase = hsel_i & htrans_i[1] & ~hwrite_i & hready_i;
   assign rd_idx = haddr_i[13:2];

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
      begin
         wr_pend_q <= 1'b0;
         wr_idx_q <= 12'h000;
      end
      else if (hready_i)
      begin
         wr_pend_q <= hsel_i & htrans_i[1] & hwrite_i;
         wr_idx_q <= haddr_i[13:2];
      end
   end

   function automatic logic wr_hit(input logic [11:0] idx, input logic pend,
                                   input logic [11:0] at);
      wr_hit = pend && (at == idx);
   endfunction

   // ************************************************************
   // software registers
   // ************************************************************
   logic [7:0] input_select_q, fast_acquire_control_q, history_average_length_q;
   logic [7:0] history_delay_q, holdover_ref_count_force_q, force_holdover_q;
   logic [7:0] switching_control_q, input_alarm_masks_q, input_priority_0_1_q;
   logic [7:0] input_priority_2_3_q, seamless_switch_mode_q, coarse_phase_length_q;
   logic [7:0] coarse_phase_delay_q, force_fine_adjust_q;
   logic [23:0] holdover_cycle_count_q, fine_adjust_override_q;
   logic [15:0] phase_measure_threshold_q;
   logic [STEP_W-1:0] frequency_step_word_q;
   logic [31:0] wd;
   assign wd = hwdata_i;

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
      begin
         input_select_q <= 8'h00;
         fast_acquire_control_q <= 8'h00;
         history_average_length_q <= 8'h00;
         history_delay_q <= 8'h00;
         holdover_ref_count_force_q <= 8'h00;
         holdover_cycle_count_q <= 24'h000000;
         force_holdover_q <= 8'h00;
         switching_control_q <= 8'h00;
         input_alarm_masks_q <= 8'h00;
         input_priority_0_1_q <= 8'h00;
         input_priority_2_3_q <= 8'h00;
         seamless_switch_mode_q <= SEAMLESS_RST;
         phase_measure_threshold_q <= 16'h0000;
         coarse_phase_length_q <= 8'h00;
         coarse_phase_delay_q <= 8'h00;
         fine_adjust_override_q <= 24'h000000;
         force_fine_adjust_q <= 8'h00;
         frequency_step_word_q <= '0;
      end
      else
      begin
         if (wr_hit(IDX_INPUT_SELECT, wr_pend_q, wr_idx_q))
            input_select_q <= {5'h00, wd[SEL_W-1:0]}; // R2
         if (wr_hit(IDX_FAST_ACQ, wr_pend_q, wr_idx_q))
            fast_acquire_control_q <= {6'h00, wd[1:0]};
         if (wr_hit(IDX_HIST_LEN, wr_pend_q, wr_idx_q))
            history_average_length_q <= {3'h0, wd[LEN_W-1:0]};
         if (wr_hit(IDX_HIST_DELAY, wr_pend_q, wr_idx_q))
            history_delay_q <= {3'h0, wd[LEN_W-1:0]};
         if (wr_hit(IDX_REF_COUNT_FRC, wr_pend_q, wr_idx_q))
            holdover_ref_count_force_q <= {3'h0, wd[4:0]};
         if (wr_hit(IDX_CYC_COUNT, wr_pend_q, wr_idx_q))
            holdover_cycle_count_q <= wd[23:0];
         if (wr_hit(IDX_FORCE_HOLD, wr_pend_q, wr_idx_q))
            force_holdover_q <= {7'h00, wd[FH_BIT]};
         if (wr_hit(IDX_SWITCH_CTRL, wr_pend_q, wr_idx_q))
            switching_control_q <= {5'h00, wd[2:0]};
         if (wr_hit(IDX_ALARM_MASKS, wr_pend_q, wr_idx_q))
            input_alarm_masks_q <= wd[7:0];
         if (wr_hit(IDX_PRIO_01, wr_pend_q, wr_idx_q))
            input_priority_0_1_q <= {1'b0, wd[6:4], 1'b0, wd[2:0]}; // R15
         if (wr_hit(IDX_PRIO_23, wr_pend_q, wr_idx_q))
            input_priority_2_3_q <= {1'b0, wd[6:4], 1'b0, wd[2:0]}; // R15
         if (wr_hit(IDX_SEAMLESS_MODE, wr_pend_q, wr_idx_q))
            seamless_switch_mode_q <= {4'h0, wd[3:0]};
         if (wr_hit(IDX_PHASE_THR, wr_pend_q, wr_idx_q))
            phase_measure_threshold_q <= {6'h00, wd[9:0]}; // R17
         if (wr_hit(IDX_COARSE_LEN, wr_pend_q, wr_idx_q))
            coarse_phase_length_q <= {3'h0, wd[4:0]};
         if (wr_hit(IDX_COARSE_DLY, wr_pend_q, wr_idx_q))
            coarse_phase_delay_q <= {3'h0, wd[4:0]};
         if (wr_hit(IDX_FINE_ADJ, wr_pend_q, wr_idx_q))
            fine_adjust_override_q <= {6'h00, wd[17:0]};
         if (wr_hit(IDX_FORCE_FINE, wr_pend_q, wr_idx_q))
            force_fine_adjust_q <= {6'h00, wd[1], 1'b0};
         if (wr_hit(IDX_STEP_WORD_LO, wr_pend_q, wr_idx_q))
            frequency_step_word_q[31:0] <= wd;
         if (wr_hit(IDX_STEP_WORD_HI, wr_pend_q, wr_idx_q))
            frequency_step_word_q[STEP_W-1:32] <= wd[STEP_W-33:0];
      end
   end

   // ************************************************************
   // feedback numerator stepping
   // ************************************************************
   logic [STEP_W-1:0] numer_q;
   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
         numer_q <= '0;
      else if (wr_hit(IDX_NUMER_LO, wr_pend_q, wr_idx_q))
         numer_q[31:0] <= wd;
      else if (wr_hit(IDX_NUMER_HI, wr_pend_q, wr_idx_q))
         numer_q[STEP_W-1:32] <= wd[STEP_W-33:0];
      else if (wr_hit(IDX_STEP_CMD, wr_pend_q, wr_idx_q) && (wd[CMD_INC_BIT] != wd[CMD_DEC_BIT]))
      begin
         if (wd[CMD_INC_BIT])
            numer_q <= numer_q + frequency_step_word_q; // R1
         else
            numer_q <= numer_q - frequency_step_word_q; // R1
      end
   end

   // ************************************************************
   // alarm synchronisers (three stages, second and third agree)
   // ************************************************************
   logic [2*NUM_IN-1:0] al_s1_q, al_s2_q, al_s3_q, al_q;
   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
      begin
         al_s1_q <= '0;
         al_s2_q <= '0;
         al_s3_q <= '0;
         al_q <= '0;
      end
      else
      begin
         al_s1_q <= {freq_deviation_alarm_i, signal_loss_alarm_i};
         al_s2_q <= al_s1_q;
         al_s3_q <= al_s2_q;
         for (int i = 0; i < 2*NUM_IN; i++)
            if (al_s2_q[i] == al_s3_q[i])
               al_q[i] <= al_s3_q[i];
      end
   end

   logic lk_s1_q, lk_s2_q, lk_s3_q, locked_q;
   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
      begin
         lk_s1_q <= 1'b0;
         lk_s2_q <= 1'b0;
         lk_s3_q <= 1'b0;
         locked_q <= 1'b0;
      end
      else
      begin
         lk_s1_q <= loop_locked_i;
         lk_s2_q <= lk_s1_q;
         lk_s3_q <= lk_s2_q;
         if (lk_s2_q == lk_s3_q)
            locked_q <= lk_s3_q;
      end
   end

   // ************************************************************
   // input qualification and selection
   // ************************************************************
   logic [NUM_IN-1:0] good;
   logic [PRIO_W-1:0] rank [NUM_IN];
   assign rank[0] = input_priority_0_1_q[PRIO_W-1:0];
   assign rank[1] = input_priority_0_1_q[PRIO_HI_LSB+:PRIO_W];
   assign rank[2] = input_priority_2_3_q[PRIO_W-1:0];
   assign rank[3] = input_priority_2_3_q[PRIO_HI_LSB+:PRIO_W];

   always_comb
   begin
      for (int n = 0; n < NUM_IN; n++)
         good[n] = ~(al_q[LOS_LSB+n] & ~input_alarm_masks_q[LOS_LSB+n]) // R11 R13
                   & ~(al_q[OOF_LSB+n] & ~input_alarm_masks_q[OOF_LSB+n]); // R12 R13
   end

   logic best_ok;
   logic [1:0] best;
   logic [PRIO_W-1:0] best_rank;
   always_comb
   begin
      best_ok = 1'b0;
      best = 2'h0;
      best_rank = PRIO_MAX;
      for (int n = NUM_IN-1; n >= 0; n--)
         if (good[n] && rank[n] != PRIO_NONE && rank[n] <= PRIO_MAX // R15
             && (!best_ok || rank[n] <= best_rank)) // R22
         begin
            best_ok = 1'b1;
            best = 2'(n);
            best_rank = rank[n];
         end
   end

   logic [1:0] sel_q;
   logic [1:0] mode;
   logic cur_ok;
   logic usable;
   assign mode = switching_control_q[1:0];
   assign cur_ok = good[sel_q] && rank[sel_q] != PRIO_NONE && rank[sel_q] <= PRIO_MAX;
   always_comb
   begin
      case (mode)
         MODE_MANUAL: usable = good[input_select_q[1:0]] && input_select_q[2] == 1'b0; // R2
         MODE_NONREV, MODE_REV: usable = best_ok;
         default: usable = 1'b0; // R9
      endcase
   end

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
         sel_q <= 2'h0;
      else
      begin
         case (mode) // R9
            MODE_MANUAL:
               if (input_select_q[2] == 1'b0)
                  sel_q <= input_select_q[1:0]; // R2
            MODE_NONREV:
               if (!cur_ok && best_ok)
                  sel_q <= best; // R22
            MODE_REV:
               if (best_ok)
                  sel_q <= best; // R23
            default: sel_q <= sel_q;
         endcase
      end
   end

   // ************************************************************
   // history tick and averaging window
   // ************************************************************
   logic [7:0] tick_cnt_q;
   logic tick;
   assign tick = (tick_cnt_q == 8'(TICK_CYC - 1));
   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i || tick)
         tick_cnt_q <= 8'h00;
      else
         tick_cnt_q <= tick_cnt_q + 8'h01;
   end

   rish_state_e state_q;
   logic [31:0] win_cnt_q, dly_cnt_q, win_len, dly_len;
   logic [HF_W+31:0] acc_q;
   logic [HF_W-1:0] avg_q, held_q;
   logic valid_q;
   assign win_len = (32'h1 << history_average_length_q[LEN_W-1:0]) - 32'h1; // R5
   assign dly_len = 32'h1 << history_delay_q[LEN_W-1:0]; // R6

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
      begin
         state_q <= RISH_ACQ;
         win_cnt_q <= '0;
         dly_cnt_q <= '0;
         acc_q <= '0;
         avg_q <= '0;
         held_q <= '0;
         valid_q <= 1'b0;
      end
      else
      begin
         case (state_q)
            RISH_ACQ:
            begin
               // fresh input: history cleared and restarted
               acc_q <= '0; // R21
               avg_q <= '0; // R21
               win_cnt_q <= '0;
               dly_cnt_q <= '0;
               valid_q <= 1'b0; // R21
               if (force_holdover_q[FH_BIT] || !usable)
                  state_q <= RISH_HOLD;
               else
                  state_q <= RISH_TRACK;
            end
            RISH_TRACK:
            begin
               if (force_holdover_q[FH_BIT] || !usable) // R8 R14
                  state_q <= RISH_HOLD; // R20
               else if (tick)
               begin
                  if (win_cnt_q + 32'h1 >= win_len)
                  begin
                     avg_q <= HF_W'((acc_q + input_freq_i) / (win_cnt_q + 32'h1)); // R5
                     acc_q <= '0;
                     win_cnt_q <= '0;
                     dly_cnt_q <= '0;
                  end
                  else
                  begin
                     acc_q <= acc_q + input_freq_i;
                     win_cnt_q <= win_cnt_q + 32'h1;
                  end
                  // the average becomes history only once it is older than the delay
                  if (dly_cnt_q + 32'h1 >= dly_len)
                  begin
                     held_q <= avg_q; // R6
                     valid_q <= valid_q | (avg_q != '0);
                  end
                  else
                     dly_cnt_q <= dly_cnt_q + 32'h1;
               end
            end
            RISH_HOLD:
               if (!force_holdover_q[FH_BIT] && usable)
                  state_q <= RISH_ACQ; // R21
            default: state_q <= RISH_ACQ;
         endcase
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   logic fast_d;
   assign fast_d = fast_acquire_control_q[FA_FORCE_BIT] // R4
                   | (fast_acquire_control_q[FA_AUTO_BIT] & ~locked_q); // R3

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
      begin
         active_input_o <= 2'h0;
         holdover_o <= 1'b0;
         freerun_o <= 1'b0;
         fast_acquire_o <= 1'b0;
         seamless_switch_enable_o <= 1'b0;
         holdover_freq_o <= '0;
         divider_numerator_o <= '0;
      end
      else
      begin
         active_input_o <= sel_q;
         holdover_o <= (state_q == RISH_HOLD) & valid_q; // R18
         freerun_o <= (state_q == RISH_HOLD) & ~valid_q; // R18
         fast_acquire_o <= fast_d; // R19
         seamless_switch_enable_o <= switching_control_q[SC_STYLE_BIT]; // R10
         holdover_freq_o <= (state_q == RISH_HOLD) ? held_q : input_freq_i; // R7
         divider_numerator_o <= numer_q;
      end
   end

   // ************************************************************
   // read data
   // ************************************************************
   logic [31:0] rd_d;
   always_comb
   begin
      case (rd_idx)
         IDX_INPUT_SELECT: rd_d = {24'h0, input_select_q};
         IDX_FAST_ACQ: rd_d = {24'h0, fast_acquire_control_q};
         IDX_HIST_LEN: rd_d = {24'h0, history_average_length_q};
         IDX_HIST_DELAY: rd_d = {24'h0, history_delay_q};
         IDX_REF_COUNT_FRC: rd_d = {24'h0, holdover_ref_count_force_q};
         IDX_CYC_COUNT: rd_d = {8'h0, holdover_cycle_count_q};
         IDX_FORCE_HOLD: rd_d = {24'h0, force_holdover_q};
         IDX_SWITCH_CTRL: rd_d = {24'h0, switching_control_q};
         IDX_ALARM_MASKS: rd_d = {24'h0, input_alarm_masks_q};
         IDX_PRIO_01: rd_d = {24'h0, input_priority_0_1_q};
         IDX_PRIO_23: rd_d = {24'h0, input_priority_2_3_q};
         IDX_SEAMLESS_MODE: rd_d = {24'h0, seamless_switch_mode_q}; // R16
         IDX_PHASE_THR: rd_d = {16'h0, phase_measure_threshold_q};
         IDX_COARSE_LEN: rd_d = {24'h0, coarse_phase_length_q};
         IDX_COARSE_DLY: rd_d = {24'h0, coarse_phase_delay_q};
         IDX_STATUS: rd_d = {27'h0, freerun_o, holdover_o, fast_acquire_o, valid_q, 1'b0};
         IDX_FINE_ADJ: rd_d = {8'h0, fine_adjust_override_q};
         IDX_FORCE_FINE: rd_d = {24'h0, force_fine_adjust_q};
         IDX_STEP_WORD_LO: rd_d = frequency_step_word_q[31:0];
         IDX_STEP_WORD_HI: rd_d = {8'h0, frequency_step_word_q[STEP_W-1:32]};
         IDX_ACTIVE: rd_d = {30'h0, sel_q};
         IDX_NUMER_LO: rd_d = numer_q[31:0];
         IDX_NUMER_HI: rd_d = {8'h0, numer_q[STEP_W-1:32]};
         IDX_HOLD_FREQ: rd_d = held_q;
         default: rd_d = 32'h0;
      endcase
   end

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
      begin
         hrdata_o <= 32'h0;
         hreadyout_o <= 1'b1;
         hresp_o <= 1'b0;
      end
      else
      begin
         if (rd_phase)
            hrdata_o <= rd_d;
         hreadyout_o <= 1'b1;
         hresp_o <= 1'b0;
      end
   end
endmodule // rish_ctrl

// file: sim/rish_ctrl_sva.sv
// assertions on the ports of rish_ctrl
// assumes a bind from the bench top file; one clock, sync reset
`timescale 1ns/1ps
module rish_ctrl_sva
(
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire logic hsel_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic hready_i,
   input wire logic [31:0] hrdata_o,
   input wire logic hreadyout_o,
   input wire logic hresp_o,
   input wire logic [rish_pkg::HF_W-1:0] input_freq_i,
   input wire logic holdover_o,
   input wire logic freerun_o,
   input wire logic seamless_switch_enable_o,
   input wire logic [rish_pkg::HF_W-1:0] holdover_freq_o,
   input wire logic [rish_pkg::STEP_W-1:0] divider_numerator_o
);
   import rish_pkg::*;
   logic tk, wr_q, rd_q;
   logic [1:0] age_q;
   assign tk = hsel_i && htrans_i[1] && hready_i;
   // data phase markers and cycles since reset
   always_ff @(posedge core_clk_i)
   begin
      wr_q <= !sys_rst_i && tk && hwrite_i;
      rd_q <= !sys_rst_i && tk && !hwrite_i;
      age_q <= sys_rst_i ? 2'h0 : age_q + {1'h0, age_q != 2'h3};
   end
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);
   AST_OKAY: assert property (hresp_o == 1'h0)
      else $error("response not okay");
   AST_NO_WAIT: assert property (hreadyout_o == 1'h1)
      else $error("wait state inserted");
   AST_RDATA_STANDS: assert property ($changed(hrdata_o) |-> rd_q || $past(rd_q))
      else $error("read data moved without a read");
   AST_HOLD_FREE_EXCL: assert property (!(holdover_o && freerun_o))
      else $error("holdover and freerun together");
   AST_TRACK_FREQ: assert property ((age_q == 2'h3) ##0 (!(holdover_o || freerun_o))[*3]
      |-> $past(holdover_freq_o) == $past(input_freq_i, 2)) else $error("tracking freq wrong");
   AST_HELD_STABLE: assert property (holdover_o ##1 holdover_o |-> $stable(holdover_freq_o))
      else $error("held frequency moved");
   AST_NUMER_BY_WRITE: assert property ($changed(divider_numerator_o)
      |-> $past(wr_q) || $past(wr_q, 2) || $past(wr_q, 3)) else $error("numerator moved alone");
   AST_STYLE_BY_WRITE: assert property ($changed(seamless_switch_enable_o)
      |-> $past(wr_q) || $past(wr_q, 2)) else $error("switch style moved alone");
endmodule // rish_ctrl_sva

// file: sim/rish_ctrl_tb.sv
// self-checking bench for rish_ctrl: register rows, then hand-written cases
// assumes rish_pkg compiled first and the checker file beside it
`timescale 1ns/1ps
module rish_ctrl_tb;
   import rish_pkg::*;
   logic clk = 1'h0, rst = 1'h1, hsel = 1'h0, hwrite = 1'h0, locked = 1'h1;
   logic hrdy, hresp, hold, free, fast, seam;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, ifreq = 32'h3E8, hrdata, hfreq, q;
   logic [1:0] htrans = 2'h0, act;
   logic [2:0] hsize = 3'h2;
   logic [3:0] signal_loss_alarm = 4'h0, freq_deviation_alarm = 4'h0;
   logic [55:0] numer;
   int n_fail = 0, total_checks = 0, cyc = 0;
   localparam logic [11:0] RI [9] = '{IDX_INPUT_SELECT, IDX_FAST_ACQ, IDX_HIST_LEN,
      IDX_HIST_DELAY, IDX_SWITCH_CTRL, IDX_ALARM_MASKS, IDX_PRIO_01, IDX_PHASE_THR, 12'h460};
   localparam logic [31:0] RE [9] = '{32'h7, 32'h3, 32'h1F, 32'h1F, 32'h7, 32'hFF, 32'h77,
      32'h3FF, 32'h0};
   localparam logic [31:0] CM [3] = '{32'h1, 32'h3, 32'h2};
   localparam logic [55:0] NE [3] = '{56'h100000008, 56'h100000008, 56'hFFFFFFF8};
   localparam logic [7:0] MK [9] = '{8'h0, 8'h0, 8'h2, 8'h2, 8'h20, 8'h0, 8'h0, 8'h0, 8'h0};
   localparam logic [7:0] MD [9] = '{8'h2, 8'h2, 8'h2, 8'h2, 8'h2, 8'h1, 8'h1, 8'h2, 8'h0};
   localparam logic [3:0] LS [9] = '{4'h0, 4'h2, 4'h2, 4'h0, 4'h0, 4'h2, 4'h0, 4'h0, 4'h0};
   localparam logic [3:0] OF [9] = '{4'h0, 4'h0, 4'h0, 4'h2, 4'h2, 4'h0, 4'h0, 4'h0, 4'h0};
   localparam logic [1:0] EA [9] = '{2'h1, 2'h0, 2'h1, 2'h0, 2'h1, 2'h0, 2'h0, 2'h1, 2'h2};
   always #10 clk = ~clk;
   rish_ctrl dut_u (.core_clk_i(clk), .sys_rst_i(rst), .hsel_i(hsel), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hrdy),
      .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp), .signal_loss_alarm_i(signal_loss_alarm),
      .freq_deviation_alarm_i(freq_deviation_alarm), .loop_locked_i(locked), .input_freq_i(ifreq),
      .active_input_o(act), .holdover_o(hold), .freerun_o(free), .fast_acquire_o(fast),
      .seamless_switch_enable_o(seam), .holdover_freq_o(hfreq), .divider_numerator_o(numer));
   task chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task give_verdict;
      if (n_fail == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // one single AHB-Lite transfer; read data lands in q
   task bus(input logic w, input logic [11:0] idx, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'h1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {18'h0, idx, 2'h0};
      do @(posedge clk); while (hrdy !== 1'h1);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hrdy !== 1'h1);
      q = hrdata;
   endtask
   task wt(input int n);
      repeat (n) @(posedge clk);
   endtask
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 4000)
      begin
         n_fail++;
         give_verdict();
      end
   end
   initial
   begin
      wt(12);
      rst <= 1'h0;
      bus(1'h0, IDX_SEAMLESS_MODE, 32'h0);
      chk("mode_rst", q, 32'h2);
      chk("numer_rst", numer, 56'h0);
      for (int i = 0; i < 9; i++)
      begin
         bus(1'h1, RI[i], 32'hFFFFFFFF);
         bus(1'h0, RI[i], 32'h0);
         chk("reg", q, RE[i]);
      end
      chk("style_on", seam, 1'h1);
      for (int i = 0; i < 8; i++)
      begin
         bus(1'h1, IDX_FAST_ACQ, i);
         locked <= i[2];
         wt(8);
         chk("fast", fast, i[1] | (i[0] & ~i[2]));
         bus(1'h0, IDX_STATUS, 32'h0);
         chk("fast_flag", q[ST_FAST_BIT], i[1] | (i[0] & ~i[2]));
      end
      bus(1'h1, IDX_FAST_ACQ, 32'h0);
      bus(1'h1, IDX_NUMER_LO, 32'hFFFFFFF8);
      bus(1'h1, IDX_NUMER_HI, 32'h0);
      bus(1'h1, IDX_STEP_WORD_LO, 32'h10);
      bus(1'h1, IDX_STEP_WORD_HI, 32'h0);
      for (int i = 0; i < 3; i++)
      begin
         bus(1'h1, IDX_STEP_CMD, CM[i]);
         wt(4);
         chk("numer", numer, NE[i]);
      end
      bus(1'h1, IDX_PRIO_01, 32'h12);
      bus(1'h1, IDX_PRIO_23, 32'h3);
      bus(1'h1, IDX_INPUT_SELECT, 32'h2);
      for (int i = 0; i < 9; i++)
      begin
         bus(1'h1, IDX_ALARM_MASKS, MK[i]);
         bus(1'h1, IDX_SWITCH_CTRL, MD[i]);
         signal_loss_alarm <= LS[i];
         freq_deviation_alarm <= OF[i];
         wt(8);
         chk("act", act, EA[i]);
      end
      chk("style_off", seam, 1'h0);
      bus(1'h1, IDX_INPUT_SELECT, 32'h5);
      wt(8);
      chk("sel_rsvd", act, 2'h2);
      bus(1'h1, IDX_SWITCH_CTRL, 32'h2);
      signal_loss_alarm <= 4'h7;
      wt(8);
      chk("no_input", hold | free, 1'h1);
      signal_loss_alarm <= 4'h0;
      bus(1'h1, IDX_HIST_LEN, 32'h0);
      bus(1'h1, IDX_HIST_DELAY, 32'h0);
      wt(400);
      bus(1'h0, IDX_STATUS, 32'h0);
      chk("hist_valid", q[ST_VALID_BIT], 1'h1);
      bus(1'h1, IDX_FORCE_HOLD, 32'h1);
      ifreq <= 32'h7D0;
      wt(40);
      chk("forced", hold, 1'h1);
      chk("held", hfreq, 32'h3E8);
      bus(1'h1, IDX_FORCE_HOLD, 32'h0);
      wt(4);
      bus(1'h0, IDX_STATUS, 32'h0);
      chk("hist_restart", q[ST_VALID_BIT], 1'h0);
      chk("released", hold, 1'h0);
      give_verdict();
   end
endmodule // rish_ctrl_tb
bind rish_ctrl rish_ctrl_sva chk_u (.*);
